// [shared/mau_cfg.svh]
`ifndef MAU_CFG_SVH
`define MAU_CFG_SVH
// Datapath widths and field positions
`define MAU_W        32
`define MAU_HW       16
`define MAU_DW       64
`define MAU_WHW      48
`define MAU_HI_LSB   16
`define MAU_HI_MSB   31
`define MAU_LO_MSB   15
`define MAU_WH_KEEP  16
// Predicate codes
`define MAU_CC_EQ    4'h0
`define MAU_CC_NE    4'h1
`define MAU_CC_CS    4'h2
`define MAU_CC_CC    4'h3
`define MAU_CC_MI    4'h4
`define MAU_CC_PL    4'h5
`define MAU_CC_VS    4'h6
`define MAU_CC_VC    4'h7
`define MAU_CC_HI    4'h8
`define MAU_CC_LS    4'h9
`define MAU_CC_GE    4'ha
`define MAU_CC_LT    4'hb
`define MAU_CC_GT    4'hc
`define MAU_CC_LE    4'hd
`define MAU_CC_AL    4'he
// Condition flag bit positions
`define MAU_FL_N     3
`define MAU_FL_Z     2
`define MAU_FL_C     1
`define MAU_FL_V     0
`define MAU_SAT_RST  1'b0
`endif

// [shared/mau_pkg.sv]
`default_nettype none
package mau_pkg;
   typedef enum logic [3:0] {
      mau_unsigned_long_multiply,
      mau_unsigned_double_accumulate_multiply,
      mau_unsigned_long_mac,
      mau_signed_word_halfword_mac,
      mau_signed_halfword_mac,
      mau_signed_dual_halfword_mac,
      mau_signed_long_word_mac,
      mau_signed_dual_halfword_long_mac,
      mau_signed_halfword_long_mac
   } mau_op_t;

   typedef struct packed {
      logic        valid;
      mau_op_t     op;
      logic [3:0]  cond;
      logic [3:0]  nzcv;
      logic        first_top;
      logic        second_top;
      logic        exchange;
      logic [31:0] first_source;
      logic [31:0] second_source;
      logic [31:0] addend_source;
      logic [31:0] result_low_word;
      logic [31:0] result_high_word;
   } mau_req_t;

   typedef struct packed {
      logic        valid;
      logic        wr_low;
      logic        wr_high;
      logic [31:0] result_low_word;
      logic [31:0] result_high_word;
   } mau_res_t;
endpackage : mau_pkg
`default_nettype wire

// [core/mau_unit.sv]
// How it works
// - Unsigned long forms: full 64-bit unsigned product
// - Product low word to low, high to high
// - Double-accumulate first adds old high word
// - Then adds old low word, splits result
// - Unsigned long mac adds high:low pair
// - Long forms leave condition flags untouched
// - Write happens only when predicate passes
// - Halfword mac picks selected signed halfwords
// - Halfword mac adds addend, writes 32 bits
// - Word-halfword mac keeps top 32 of 48
// - 32-bit accumulate overflow sets saturation flag
// - Dual form splits operands into signed halfwords
// - Exchange swaps second operand halfwords
// - Dual form adds both products plus addend
// - Dual accumulate overflow sets saturation flag
// - Signed long word mac: signed 64-bit sum
// - Low word is bits 31..0, high 63..32
// - Long halfword product sign-extended, accumulated
// - Long dual adds both products to pair
`timescale 1ns/1ps
`default_nettype none
`include "mau_cfg.svh"

module mau_unit (
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   input  wire mau_pkg::mau_req_t req_i,
   input  wire logic             sat_clear_i,
   output var  mau_pkg::mau_res_t res_o,
   output logic                  sat_o
);

   localparam int W  = `MAU_W;
   localparam int HW = `MAU_HW;
   localparam int DW = `MAU_DW;

   // Predicate evaluation on the flags as decode sees them
   function automatic logic cond_pass(input logic [3:0] cc,
                                      input logic [3:0] f);
      logic n;
      logic z;
      logic c;
      logic v;
      logic r;
      n = f[`MAU_FL_N];
      z = f[`MAU_FL_Z];
      c = f[`MAU_FL_C];
      v = f[`MAU_FL_V];
      case (cc)
         `MAU_CC_EQ: r = z;
         `MAU_CC_NE: r = !z;
         `MAU_CC_CS: r = c;
         `MAU_CC_CC: r = !c;
         `MAU_CC_MI: r = n;
         `MAU_CC_PL: r = !n;
         `MAU_CC_VS: r = v;
         `MAU_CC_VC: r = !v;
         `MAU_CC_HI: r = c && !z;
         `MAU_CC_LS: r = !c || z;
         `MAU_CC_GE: r = (n == v);
         `MAU_CC_LT: r = (n != v);
         `MAU_CC_GT: r = !z && (n == v);
         `MAU_CC_LE: r = z || (n != v);
         // Always, and the unused code treated as always
         default:    r = 1'b1;
      endcase
      return r;
   endfunction : cond_pass

   logic                 pass_w;
   logic                 go_w;
   logic [W-1:0]         a_w;
   logic [W-1:0]         b_w;
   logic [HW-1:0]        a_sel;
   logic [HW-1:0]        b_sel;
   logic [HW-1:0]        a_lo;
   logic [HW-1:0]        a_hi;
   logic [HW-1:0]        b_for_lo;
   logic [HW-1:0]        b_for_hi;
   logic [DW-1:0]        acc64;
   logic [DW-1:0]        uprod;
   logic [DW-1:0]        sprod;
   logic [W-1:0]         hprod;
   logic [`MAU_WHW-1:0]  whprod;
   logic [W-1:0]         dprod0;
   logic [W-1:0]         dprod1;
   logic [W+1:0]         sum34;
   logic [W+1:0]         t0;
   logic [W+1:0]         t1;
   logic [DW-1:0]        res64;
   logic                 long_w;
   logic                 ovf_w;
   logic                 sat_r;
   mau_pkg::mau_res_t    res_r;
   mau_pkg::mau_res_t    res_nxt;

   assign pass_w = cond_pass(req_i.cond, req_i.nzcv);
   assign go_w   = req_i.valid && pass_w;
   assign a_w    = req_i.first_source;
   assign b_w    = req_i.second_source;
   // Low destination carries bits 31..0, high carries 63..32
   assign acc64  = {req_i.result_high_word, req_i.result_low_word};

   // Selected halfwords, other halves never reach the multiplier
   assign a_sel = req_i.first_top
                ? a_w[`MAU_HI_MSB:`MAU_HI_LSB] : a_w[`MAU_LO_MSB:0];
   assign b_sel = req_i.second_top
                ? b_w[`MAU_HI_MSB:`MAU_HI_LSB] : b_w[`MAU_LO_MSB:0];

   // Dual forms: exchange swaps which half of the second operand
   assign a_lo     = a_w[`MAU_LO_MSB:0];
   assign a_hi     = a_w[`MAU_HI_MSB:`MAU_HI_LSB];
   assign b_for_lo = req_i.exchange
                   ? b_w[`MAU_HI_MSB:`MAU_HI_LSB] : b_w[`MAU_LO_MSB:0];
   assign b_for_hi = req_i.exchange
                   ? b_w[`MAU_LO_MSB:0] : b_w[`MAU_HI_MSB:`MAU_HI_LSB];

   // Unsigned: zero extension on both sides
   assign uprod  = {{W{1'b0}}, a_w} * {{W{1'b0}}, b_w};
   assign sprod  = DW'($signed(a_w) * $signed(b_w));
   assign hprod  = W'($signed(a_sel) * $signed(b_sel));
   assign whprod = `MAU_WHW'($signed(a_w) * $signed(b_sel));
   assign dprod0 = W'($signed(a_lo) * $signed(b_for_lo));
   assign dprod1 = W'($signed(a_hi) * $signed(b_for_hi));

   // 34-bit sum holds any 32-bit accumulate without loss
   always_comb begin
      t0 = {{2{req_i.addend_source[W-1]}}, req_i.addend_source};
      t1 = '0;
      unique case (req_i.op)
         mau_pkg::mau_signed_halfword_mac:
            t1 = {{2{hprod[W-1]}}, hprod};
         mau_pkg::mau_signed_word_halfword_mac:
            t1 = {{2{whprod[`MAU_WHW-1]}},
                  whprod[`MAU_WHW-1:`MAU_WH_KEEP]};
         mau_pkg::mau_signed_dual_halfword_mac:
            t1 = {{2{dprod0[W-1]}}, dprod0}
               + {{2{dprod1[W-1]}}, dprod1};
         default:
            t1 = '0;
      endcase
      sum34 = t0 + t1;
   end

   // Overflow only on the accumulate; products always fit
   assign ovf_w = (sum34[W+1:W-1] != {3{sum34[W-1]}});

   always_comb begin
      res64  = acc64;
      long_w = 1'b1;
      unique case (req_i.op)
         mau_pkg::mau_unsigned_long_multiply:
            res64 = uprod;
         mau_pkg::mau_unsigned_double_accumulate_multiply:
            res64 = uprod + {{W{1'b0}}, req_i.result_high_word}
                  + {{W{1'b0}}, req_i.result_low_word};
         mau_pkg::mau_unsigned_long_mac:
            res64 = uprod + acc64;
         mau_pkg::mau_signed_long_word_mac:
            res64 = sprod + acc64;
         mau_pkg::mau_signed_halfword_long_mac:
            res64 = {{W{hprod[W-1]}}, hprod} + acc64;
         mau_pkg::mau_signed_dual_halfword_long_mac:
            res64 = {{W{dprod0[W-1]}}, dprod0}
                  + {{W{dprod1[W-1]}}, dprod1} + acc64;
         default: begin
            res64  = {{W{1'b0}}, sum34[W-1:0]};
            long_w = 1'b0;
         end
      endcase
   end

   // 64-bit sums are plain modulo arithmetic, no flag involved
   always_comb begin
      res_nxt                  = '0;
      res_nxt.valid            = req_i.valid;
      res_nxt.wr_low           = go_w;
      res_nxt.wr_high          = go_w && long_w;
      res_nxt.result_low_word  = res64[W-1:0];
      res_nxt.result_high_word = long_w ? res64[DW-1:W] : '0;
   end

   // Result stage; no condition flag output exists, so long forms cannot touch them
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         res_r <= '0;
      end else begin
         res_r <= res_nxt;
      end
   end

   // Sticky: set beats clear in the same cycle so no overflow is lost
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sat_r <= `MAU_SAT_RST;
      end else if (go_w && !long_w && ovf_w) begin
         sat_r <= 1'b1;
      end else if (sat_clear_i) begin
         sat_r <= 1'b0;
      end
   end

   assign res_o = res_r;
   assign sat_o = sat_r;

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_issue(mau_pkg::mau_op_t o);
      req_i.valid && pass_w && req_i.op == o;
   endsequence

   sequence s_refused;
      req_i.valid && !pass_w;
   endsequence

   property p_umul_split;
      s_issue(mau_pkg::mau_unsigned_long_multiply) |=>
         res_o.wr_low && res_o.wr_high &&
         {res_o.result_high_word, res_o.result_low_word}
            == {{W{1'b0}}, $past(a_w)} * {{W{1'b0}}, $past(b_w)};
   endproperty
   a_umul_split: assert property (p_umul_split)
      else $error("unsigned long multiply result wrong");

   property p_udacc;
      s_issue(mau_pkg::mau_unsigned_double_accumulate_multiply) |=>
         {res_o.result_high_word, res_o.result_low_word}
            == {{W{1'b0}}, $past(a_w)} * {{W{1'b0}}, $past(b_w)}
             + {{W{1'b0}}, $past(req_i.result_high_word)}
             + {{W{1'b0}}, $past(req_i.result_low_word)};
   endproperty
   a_udacc: assert property (p_udacc)
      else $error("double accumulate result wrong");

   property p_umac;
      s_issue(mau_pkg::mau_unsigned_long_mac) |=>
         {res_o.result_high_word, res_o.result_low_word}
            == {{W{1'b0}}, $past(a_w)} * {{W{1'b0}}, $past(b_w)} + $past(acc64);
   endproperty
   a_umac: assert property (p_umac)
      else $error("unsigned long mac result wrong");

   property p_refused;
      s_refused |=> !res_o.wr_low && !res_o.wr_high && ($stable(sat_o) || $past(sat_clear_i));
   endproperty
   a_refused: assert property (p_refused)
      else $error("write or flag change on failed predicate");

   property p_dual_sat;
      s_issue(mau_pkg::mau_signed_dual_halfword_mac) ##0 ovf_w
         |=> sat_o ##1 (sat_o || $past(sat_clear_i));
   endproperty
   a_dual_sat: assert property (p_dual_sat)
      else $error("dual overflow did not set saturation");

   property p_hw_acc;
      s_issue(mau_pkg::mau_signed_halfword_mac) |=>
         res_o.wr_low && !res_o.wr_high &&
         res_o.result_low_word == $past(hprod) + $past(req_i.addend_source);
   endproperty
   a_hw_acc: assert property (p_hw_acc)
      else $error("halfword mac result wrong");

   property p_sticky;
      sat_o && !sat_clear_i |=> sat_o;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("saturation flag dropped without clear");

   property p_long_wrap;
      req_i.valid && long_w |=> $stable(sat_o) || $past(sat_clear_i);
   endproperty
   a_long_wrap: assert property (p_long_wrap)
      else $error("long form touched saturation flag");

   property p_slong;
      s_issue(mau_pkg::mau_signed_long_word_mac) |=>
         {res_o.result_high_word, res_o.result_low_word}
            == DW'($signed($past(a_w)) * $signed($past(b_w))) + $past(acc64);
   endproperty
   a_slong: assert property (p_slong)
      else $error("signed long mac result wrong");

   property p_hw_long;
      s_issue(mau_pkg::mau_signed_halfword_long_mac) |=>
         {res_o.result_high_word, res_o.result_low_word}
            == {{W{$past(hprod[W-1])}}, $past(hprod)} + $past(acc64);
   endproperty
   a_hw_long: assert property (p_hw_long)
      else $error("long halfword mac not sign extended");

   property p_wh_sat;
      s_issue(mau_pkg::mau_signed_word_halfword_mac) ##0 ovf_w |=> sat_o;
   endproperty
   a_wh_sat: assert property (p_wh_sat)
      else $error("word halfword overflow did not set saturation");

   property p_answer;
      req_i.valid |=> res_o.valid;
   endproperty
   a_answer: assert property (p_answer)
      else $error("request gave no answer one cycle later");

   property p_idle;
      !req_i.valid |=> !res_o.valid && !res_o.wr_low && !res_o.wr_high;
   endproperty
   a_idle: assert property (p_idle)
      else $error("write without a request");

   property p_hw_sat;
      s_issue(mau_pkg::mau_signed_halfword_mac) ##0 ovf_w |=> sat_o;
   endproperty
   a_hw_sat: assert property (p_hw_sat)
      else $error("halfword overflow did not set saturation");

   property p_no_false_sat;
      !sat_o && !(req_i.valid && pass_w && ovf_w) |=> !sat_o;
   endproperty
   a_no_false_sat: assert property (p_no_false_sat)
      else $error("saturation set without overflow");

   property p_wh_acc;
      s_issue(mau_pkg::mau_signed_word_halfword_mac) |=>
         res_o.wr_low && !res_o.wr_high &&
         res_o.result_low_word
            == W'($past(whprod) >> `MAU_WH_KEEP) + $past(req_i.addend_source);
   endproperty
   a_wh_acc: assert property (p_wh_acc)
      else $error("word halfword mac result wrong");

   property p_dual_long;
      s_issue(mau_pkg::mau_signed_dual_halfword_long_mac) |=>
         res_o.wr_low && res_o.wr_high &&
         {res_o.result_high_word, res_o.result_low_word}
            == DW'($signed($past(dprod0))) + DW'($signed($past(dprod1))) + $past(acc64);
   endproperty
   a_dual_long: assert property (p_dual_long)
      else $error("long dual mac result wrong");

   property p_short_high;
      res_o.wr_low && !res_o.wr_high |-> res_o.result_high_word == '0;
   endproperty
   a_short_high: assert property (p_short_high)
      else $error("32-bit form left a high word");

   property p_pair_order;
      res_o.wr_high |-> res_o.wr_low;
   endproperty
   a_pair_order: assert property (p_pair_order)
      else $error("high word written without low word");

endmodule : mau_unit
`default_nettype wire

// [verif/mau_rf_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mau_rf_model (
   input  wire logic              sys_clk_i,
   input  wire mau_pkg::mau_res_t res_i,
   output var  mau_pkg::mau_req_t req_o
);
   logic [31:0] rf [16];
   logic [3:0]  lo_x, hi_x, lo_q, hi_q;
   initial req_o = '0;
   task automatic put(input logic [3:0] i, input logic [31:0] v);
      rf[i] = v;
   endtask : put
   // Callers keep indices 13 and 15 out and low apart from high
   task automatic issue(input mau_pkg::mau_op_t op, input logic [3:0] cnd, nz,
                        input logic [2:0] sel, input logic [3:0] n, m, a, lo, hi);
      req_o.valid            = 1'b1;
      req_o.op               = op;
      req_o.cond             = cnd;
      req_o.nzcv             = nz;
      req_o.first_top        = sel[2];
      req_o.second_top       = sel[1];
      req_o.exchange         = sel[0];
      req_o.first_source     = rf[n];
      req_o.second_source    = rf[m];
      req_o.addend_source    = rf[a];
      req_o.result_low_word  = rf[lo];
      req_o.result_high_word = rf[hi];
      lo_x                   = lo;
      hi_x                   = hi;
   endtask : issue
   task automatic idle();
      req_o.valid = 1'b0;
   endtask : idle
   // Indices follow the request one stage so back-to-back issue writes the right pair
   always @(posedge sys_clk_i) begin
      lo_q <= lo_x;
      hi_q <= hi_x;
      if (res_i.wr_low) rf[lo_q] <= res_i.result_low_word;
      if (res_i.wr_high) rf[hi_q] <= res_i.result_high_word;
   end
endmodule : mau_rf_model
`default_nettype wire

// [verif/test_mau_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module test_mau_unit;
   logic              sys_clk_i, resetn_i, sat_clear_i, sat, sat_exp;
   mau_pkg::mau_req_t req;
   mau_pkg::mau_res_t res;
   int                fails = 0;
   int                total_checks = 0;
   mau_unit i_mau_unit (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req),
                        .sat_clear_i(sat_clear_i), .res_o(res), .sat_o(sat));
   mau_rf_model i_mau_rf_model (.sys_clk_i(sys_clk_i), .res_i(res), .req_o(req));
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   function automatic logic pass_of(input logic [3:0] c, f);
      logic r;
      case (c[3:1])
         3'h0: r = f[2];
         3'h1: r = f[1];
         3'h2: r = f[3];
         3'h3: r = f[0];
         3'h4: r = f[1] & ~f[2];
         3'h5: r = f[3] == f[0];
         3'h6: r = ~f[2] & (f[3] == f[0]);
         default: r = 1'b1;
      endcase
      return (c[0] && c[3:1] != 3'h7) ? ~r : r;
   endfunction : pass_of
   function automatic logic is32(input mau_pkg::mau_op_t op);
      return op inside {mau_pkg::mau_signed_word_halfword_mac, mau_pkg::mau_signed_halfword_mac,
                        mau_pkg::mau_signed_dual_halfword_mac};
   endfunction : is32
   function automatic logic [64:0] ref_of(input mau_pkg::mau_op_t op, input logic [2:0] sel,
                                          input logic [31:0] n, m, a, lo, hi);
      logic signed [63:0] acc, s, p1, p2, h1, h2;
      logic [63:0]        u;
      acc = {hi, lo};
      u   = {32'h0, n} * {32'h0, m};
      h1  = $signed(sel[2] ? n[31:16] : n[15:0]);
      h2  = $signed(sel[1] ? m[31:16] : m[15:0]);
      p1  = $signed(n[15:0]) * $signed(sel[0] ? m[31:16] : m[15:0]);
      p2  = $signed(n[31:16]) * $signed(sel[0] ? m[15:0] : m[31:16]);
      case (op)
         mau_pkg::mau_unsigned_long_multiply: s = u;
         mau_pkg::mau_unsigned_double_accumulate_multiply:
            s = u + {32'h0, hi} + {32'h0, lo};
         mau_pkg::mau_unsigned_long_mac: s = u + {hi, lo};
         mau_pkg::mau_signed_word_halfword_mac:
            s = (($signed(n) * h2) >>> 16) + $signed(a);
         mau_pkg::mau_signed_halfword_mac: s = h1 * h2 + $signed(a);
         mau_pkg::mau_signed_dual_halfword_mac: s = p1 + p2 + $signed(a);
         mau_pkg::mau_signed_long_word_mac: s = $signed(n) * $signed(m) + acc;
         mau_pkg::mau_signed_dual_halfword_long_mac: s = p1 + p2 + acc;
         default: s = h1 * h2 + acc;
      endcase
      if (is32(op)) return {s != 64'($signed(s[31:0])), 32'h0, s[31:0]};
      return {1'b0, s};
   endfunction : ref_of
   task automatic do_op(input mau_pkg::mau_op_t op, input logic [3:0] cnd, nz,
                        input logic [2:0] sel, input logic [31:0] n, m, a, lo, hi);
      logic [64:0] e;
      logic        ok, lng;
      e       = ref_of(op, sel, n, m, a, lo, hi);
      ok      = pass_of(cnd, nz);
      lng     = !is32(op);
      sat_exp = sat_exp | (ok & e[64]);
      @(posedge sys_clk_i);
      #1;
      i_mau_rf_model.put(4'h1, n);
      i_mau_rf_model.put(4'h2, m);
      i_mau_rf_model.put(4'h3, a);
      i_mau_rf_model.put(4'h4, lo);
      i_mau_rf_model.put(4'h5, hi);
      i_mau_rf_model.issue(op, cnd, nz, sel, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5);
      @(posedge sys_clk_i);
      #1;
      i_mau_rf_model.idle();
      chk("valid", 64'(res.valid), 64'h1);
      chk("wr_low", 64'(res.wr_low), 64'(ok));
      chk("wr_high", 64'(res.wr_high), 64'(ok & lng));
      chk("sat", 64'(sat), 64'(sat_exp));
      if (ok) chk("result", {res.result_high_word, res.result_low_word}, e[63:0]);
      @(posedge sys_clk_i);
      #1;
      chk("pair", {i_mau_rf_model.rf[5], i_mau_rf_model.rf[4]},
          ok ? (lng ? e[63:0] : {hi, e[31:0]}) : {hi, lo});
   endtask : do_op
   task automatic clear_sat();
      sat_clear_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      sat_clear_i = 1'b0;
      sat_exp     = 1'b0;
      chk("sat clear", 64'(sat), 64'h0);
   endtask : clear_sat
   task automatic t_long();
      do_op(mau_pkg::mau_unsigned_long_multiply, 4'he, 4'h0, 3'h0, '1, '1, 32'h0, 32'h12, 32'h34);
      do_op(mau_pkg::mau_unsigned_double_accumulate_multiply, 4'he, 4'h0, 3'h0, '1, '1, 32'h0,
            '1, '1);
      // Wraps past 64 bits; the flag must stay low
      do_op(mau_pkg::mau_unsigned_long_mac, 4'he, 4'h0, 3'h0, 32'h80000000, 32'h3, 32'h0,
            '1, '1);
      do_op(mau_pkg::mau_signed_long_word_mac, 4'he, 4'h0, 3'h0, 32'h80000000, 32'h7fffffff, 32'h0,
            32'h1, 32'hfffffff0);
      for (int i = 0; i < 4; i++) begin
         do_op(mau_pkg::mau_signed_halfword_long_mac, 4'he, 4'h0, 3'(i << 1), 32'h8000ffff,
               32'h7fff8000, 32'h0, '1, 32'h0);
      end
      $display("long forms done");
   endtask : t_long
   task automatic t_short();
      for (int i = 0; i < 4; i++) begin
         do_op(mau_pkg::mau_signed_halfword_mac, 4'he, 4'h0, 3'(i << 1), 32'h80001234,
               32'hfffe7fff, 32'h10000000, 32'h11, 32'h22);
         do_op(mau_pkg::mau_signed_word_halfword_mac, 4'he, 4'h0, 3'(i << 1), 32'h9abcdef0,
               32'h8001fffe, 32'h5, 32'h11, 32'h22);
      end
      for (int i = 0; i < 2; i++) begin
         do_op(mau_pkg::mau_signed_dual_halfword_mac, 4'he, 4'h0, 3'(i), 32'h80007fff,
               32'h12348000, 32'h1, 32'h11, 32'h22);
         do_op(mau_pkg::mau_signed_dual_halfword_long_mac, 4'he, 4'h0, 3'(i), 32'h80007fff,
               32'h12348000, 32'h0, 32'hfffffff0, 32'h7fffffff);
      end
      $display("short forms done");
   endtask : t_short
   task automatic t_sat();
      do_op(mau_pkg::mau_signed_halfword_mac, 4'he, 4'h0, 3'h6, 32'h7fff0000, 32'h7fff0000,
            32'h7fffffff, 32'h0, 32'h0);
      do_op(mau_pkg::mau_signed_halfword_mac, 4'he, 4'h0, 3'h0, 32'h2, 32'h3, 32'h4, 32'h0, 32'h0);
      clear_sat();
      // Overflowing operands under a failing predicate leave the flag alone
      do_op(mau_pkg::mau_signed_dual_halfword_mac, 4'h0, 4'h0, 3'h0, 32'h7fff7fff, 32'h7fff7fff,
            32'h00020000, 32'h0, 32'h0);
      do_op(mau_pkg::mau_signed_dual_halfword_mac, 4'he, 4'h0, 3'h0, 32'h7fff7fff, 32'h7fff7fff,
            32'h00020000, 32'h0, 32'h0);
      clear_sat();
      do_op(mau_pkg::mau_signed_word_halfword_mac, 4'he, 4'h0, 3'h0, 32'h7fffffff, 32'h00007fff,
            32'h7fffffff, 32'h0, 32'h0);
      $display("saturation done");
   endtask : t_sat
   task automatic t_pred();
      for (int c = 0; c < 16; c++) begin
         for (int f = 0; f < 16; f++) begin
            do_op(mau_pkg::mau_unsigned_long_multiply, 4'(c), 4'(f), 3'h0, 32'h3, 32'h5, 32'h0,
                  32'h7, 32'h9);
         end
      end
      $display("predicates done");
   endtask : t_pred
   task automatic t_reset();
      do_op(mau_pkg::mau_signed_halfword_mac, 4'he, 4'h0, 3'h6, 32'h7fff0000, 32'h7fff0000,
            32'h7fffffff, 32'h0, 32'h0);
      @(posedge sys_clk_i);
      #1;
      i_mau_rf_model.put(4'h1, 32'h6);
      i_mau_rf_model.put(4'h2, 32'h7);
      i_mau_rf_model.issue(mau_pkg::mau_unsigned_long_multiply, 4'he, 4'h0, 3'h0, 4'h1, 4'h2,
                           4'h3, 4'h4, 4'h5);
      resetn_i = 1'b0;
      sat_exp  = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("mid reset valid", 64'(res.valid), 64'h0);
      chk("mid reset sat", 64'(sat), 64'(sat_exp));
      // The request still stands, so the first edge after release takes it
      resetn_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      i_mau_rf_model.idle();
      chk("release write", 64'({res.wr_low, res.wr_high}), 64'h3);
      chk("release result", {res.result_high_word, res.result_low_word}, 64'h2a);
      chk("release sat", 64'(sat), 64'(sat_exp));
      @(posedge sys_clk_i);
      #1;
      $display("mid-run reset done");
   endtask : t_reset
   task automatic t_b2b();
      @(posedge sys_clk_i);
      #1;
      i_mau_rf_model.put(4'h1, 32'h10);
      i_mau_rf_model.put(4'h2, 32'h20);
      i_mau_rf_model.put(4'h8, 32'h5);
      i_mau_rf_model.put(4'h9, 32'h1);
      i_mau_rf_model.issue(mau_pkg::mau_unsigned_long_multiply, 4'he, 4'h0, 3'h0, 4'h1, 4'h2,
                           4'h3, 4'h6, 4'h7);
      @(posedge sys_clk_i);
      #1;
      i_mau_rf_model.issue(mau_pkg::mau_unsigned_long_mac, 4'he, 4'h0, 3'h0, 4'h1, 4'h2,
                           4'h3, 4'h8, 4'h9);
      chk("b2b first", {res.result_high_word, res.result_low_word}, 64'h200);
      @(posedge sys_clk_i);
      #1;
      i_mau_rf_model.idle();
      chk("b2b second", {res.result_high_word, res.result_low_word}, 64'h1_0000_0205);
      @(posedge sys_clk_i);
      #1;
      chk("b2b pair", {i_mau_rf_model.rf[7], i_mau_rf_model.rf[6]}, 64'h200);
      chk("b2b acc pair", {i_mau_rf_model.rf[9], i_mau_rf_model.rf[8]}, 64'h1_0000_0205);
      $display("back to back done");
   endtask : t_b2b
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      resetn_i    = 1'b0;
      sat_clear_i = 1'b0;
      sat_exp     = 1'b0;
      repeat (10) @(posedge sys_clk_i);
      #1;
      chk("reset valid", 64'(res.valid), 64'h0);
      chk("reset sat", 64'(sat), 64'h0);
      resetn_i = 1'b1;
      t_long();
      t_short();
      t_sat();
      t_pred();
      t_reset();
      t_b2b();
      end_of_test();
   end
   initial begin
      #4000000;
      fails++;
      end_of_test();
   end
endmodule : test_mau_unit
`default_nettype wire
